// ---- hw/mpc_power_control.sv ----
`timescale 1ns/1ps
module mpc_power_control
	import mpc_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Carrier-side pins.
	input wire logic powerGoodIn,
	input wire logic powerButtonN,
	output logic supplyOnN,
	// Requests from the rest of the module.
	input wire mpc_swreq_s swReq,
	input wire logic buttonToSleep,
	input wire logic wakeEvent,
	input wire logic deepWake,
	// Onboard control and status.
	output logic [RAIL_N-1:0] railEnable,
	output logic moduleResetN,
	output mpc_status_s status
);

	// Main supply and rails are wanted in these states only.
	function automatic logic isPowered(input mpc_state_e s);
		return (s == ST_SEQ) || (s == ST_ON);
	endfunction

	logic [1:0] rawPins; // Raw pins: bit 0 power good, bit 1 button.
	logic [1:0] cleanPins; // Filtered copies of rawPins.
	logic pgFilt; // Clean power good.
	logic btnFilt; // Clean button level, low while pressed.
	logic btnPrev_r; // Button level one cycle ago, for press detection.
	logic btnPress; // One-cycle pulse on a press.

	mpc_state_e st_r; // Current power state.
	mpc_state_e st_nxt;
	mpc_state_e origin_r; // State from which deep sleep was entered.
	mpc_state_e origin_nxt;
	logic [RAIL_N-1:0] rail_r; // Onboard rail enables.
	logic [RAIL_N-1:0] rail_nxt;
	logic [STEP_W-1:0] step_r; // Cycles spent on the current rail step.
	logic [STEP_W-1:0] step_nxt;
	logic supplyOnN_r; // Registered supply request, low means on.
	logic supplyOnN_nxt;
	logic resetN_r; // Registered module reset, low holds reset.
	logic resetN_nxt;
	mpc_status_s status_r; // Registered status.
	mpc_status_s status_nxt;

	// An undriven power good pin is pulled high outside, so it reads good here.
	assign rawPins = {powerButtonN, powerGoodIn};

	// Both pins pass the same synchroniser and glitch filter.
	// Power good resets low so nothing boots before it is seen; the button resets released.
	for (genvar i = 0; i < 2; i++) begin : gFilt
		mpc_input_filter #(
			.RESET_VAL(i == 1)
		) uFilt (
			.mclk(mclk),
			.rst_n(rst_n),
			.rawIn(rawPins[i]),
			.filtOut(cleanPins[i])
		);
	end

	assign pgFilt = cleanPins[0];
	assign btnFilt = cleanPins[1];
	// A press is the falling edge of the clean level, so one push gives one event.
	assign btnPress = btnPrev_r && !btnFilt;

	// Next power state, rail stepping and deep-sleep origin.
	always_comb begin
		st_nxt = st_r;
		origin_nxt = origin_r;
		rail_nxt = rail_r;
		step_nxt = step_r;
		unique case (st_r)
			ST_SEQ: begin
				if (!pgFilt) begin
					// Nothing moves until the carrier says power is good.
					rail_nxt = RAILS_OFF;
					step_nxt = '0;
				end else if (step_r == STEP_W'(STEP_CYC - 1)) begin
					step_nxt = '0;
					if (rail_r == RAILS_ALL) begin
						st_nxt = ST_ON;
					end else begin
						rail_nxt = {rail_r[RAIL_N-2:0], 1'b1};
					end
				end else begin
					step_nxt = step_r + STEP_W'(1);
				end
			end
			ST_ON: begin
				if (!pgFilt) begin
					// Losing power good drops back into reset and restarts sequencing.
					st_nxt = ST_SEQ;
					rail_nxt = RAILS_OFF;
				end else if (btnPress) begin
					// Firmware chooses whether the button suspends or shuts down.
					st_nxt = buttonToSleep ? ST_S3 : ST_OFF;
				end else if (swReq.req && !swReq.deep) begin
					unique case (swReq.target)
						TGT_S3: st_nxt = ST_S3;
						TGT_S4: st_nxt = ST_S4;
						TGT_S5: st_nxt = ST_OFF;
						default: st_nxt = ST_ON;
					endcase
				end
			end
			ST_OFF, ST_S3, ST_S4: begin
				if (btnPress || wakeEvent) begin
					st_nxt = ST_SEQ;
				end else if (swReq.req && swReq.deep) begin
					// Remember where we came from, which also decides whether context survives.
					st_nxt = ST_DEEP;
					origin_nxt = st_r;
				end
			end
			ST_DEEP: begin
				// Only the button and the dedicated deep wake are watched here.
				if (btnPress || deepWake) begin
					st_nxt = origin_r;
				end
			end
			default: begin
				// Unused codes fall back to soft-off.
				st_nxt = ST_OFF;
			end
		endcase
		// Rails are never left on outside the powered states.
		if (!isPowered(st_nxt)) begin
			rail_nxt = RAILS_OFF;
			step_nxt = '0;
		end
	end

	// Output values, computed from the next state so they line up with it.
	always_comb begin
		supplyOnN_nxt = !isPowered(st_nxt);
		resetN_nxt = (st_nxt == ST_ON) && pgFilt;
		status_nxt.state = st_nxt;
		status_nxt.origin = origin_nxt;
		status_nxt.deep = (st_nxt == ST_DEEP);
		// Memory survives only in suspend-to-RAM, directly or under deep sleep.
		status_nxt.ctxKept = (st_nxt == ST_S3) ||
			((st_nxt == ST_DEEP) && (origin_nxt == ST_S3));
	end

	// Registers only. Reset enters sequencing so a board without a button still boots.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_SEQ;
			origin_r <= ST_OFF;
			rail_r <= RAILS_OFF;
			step_r <= '0;
			btnPrev_r <= 1'b1;
			supplyOnN_r <= 1'b0;
			resetN_r <= 1'b0;
			status_r <= '{state: ST_SEQ, origin: ST_OFF, deep: 1'b0, ctxKept: 1'b0};
		end else begin
			st_r <= st_nxt;
			origin_r <= origin_nxt;
			rail_r <= rail_nxt;
			step_r <= step_nxt;
			btnPrev_r <= btnFilt;
			supplyOnN_r <= supplyOnN_nxt;
			resetN_r <= resetN_nxt;
			status_r <= status_nxt;
		end
	end

	assign supplyOnN = supplyOnN_r;
	assign moduleResetN = resetN_r;
	assign railEnable = rail_r;
	assign status = status_r;

	// Checks on the sequencer.
	a_seq_waits_pg: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_r == ST_SEQ && !pgFilt) |=> (st_r == ST_SEQ && rail_r == RAILS_OFF))
		else $error("sequencing advanced without power good");

	a_reset_held: assert property (@(posedge mclk) disable iff (!rst_n)
		!pgFilt |=> !moduleResetN)
		else $error("module left reset while power good low");

	// Judged at the entry edge only, since a legal press may move on one cycle later.
	a_boot_undriven: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_r == ST_SEQ && pgFilt && rail_r == RAILS_ALL && step_r == STEP_W'(STEP_CYC - 1))
		|=> (st_r == ST_ON && moduleResetN))
		else $error("power-up did not complete with power good high");

	a_supply_on: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_r == ST_ON || st_r == ST_SEQ) |-> !supplyOnN)
		else $error("supply request not low while powered");

	a_button_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_r == ST_ON && pgFilt && btnPress)
		|=> (st_r == ($past(buttonToSleep) ? ST_S3 : ST_OFF)))
		else $error("button press response wrong");

	// Status is registered from the next state, so context shows at the entry edge itself.
	a_s3_entry: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_r == ST_ON && pgFilt && !btnPress && swReq.req && !swReq.deep && swReq.target == TGT_S3)
		|=> (st_r == ST_S3 && status.ctxKept && supplyOnN))
		else $error("suspend-to-RAM not entered");

	a_deep_power: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_r == ST_DEEP) |-> (supplyOnN && rail_r == RAILS_OFF && !moduleResetN))
		else $error("power left on in deep sleep");

	a_deep_limited: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_r == ST_DEEP && !btnPress && !deepWake) |=> (st_r == ST_DEEP))
		else $error("deep sleep left without a deep wake event");

	a_deep_return: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_r == ST_DEEP && (btnPress || deepWake)) |=> (st_r == $past(origin_r)))
		else $error("deep sleep did not resume into its origin");

	a_deep_entry: assert property (@(posedge mclk) disable iff (!rst_n)
		(st_r != ST_DEEP ##1 st_r == ST_DEEP)
		|-> ($past(st_r) inside {ST_S3, ST_S4, ST_OFF} && origin_r == $past(st_r)))
		else $error("deep sleep entered from an illegal state");

endmodule

// ---- hw/mpc_pkg.sv ----
package mpc_pkg;

	// Clock period of mclk in nanoseconds (10 MHz).
	localparam int CLK_PERIOD_NS = 100;

	// Glitch filter: an input must hold a new level this long before it is believed.
	localparam int FILT_NS = 10_000;
	localparam int FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_W = 8;

	// Spacing between switching on two successive onboard rails.
	localparam int STEP_NS = 200_000;
	localparam int STEP_CYC = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STEP_W = 12;

	// Number of onboard rails switched on in sequence.
	localparam int RAIL_N = 3;
	localparam logic [RAIL_N-1:0] RAILS_OFF = 3'h0;
	localparam logic [RAIL_N-1:0] RAILS_ALL = 3'h7;

	// Sleep targets that system software may request from the running state.
	localparam logic [1:0] TGT_S3 = 2'h1;
	localparam logic [1:0] TGT_S4 = 2'h2;
	localparam logic [1:0] TGT_S5 = 2'h3;

	// Power states of the module.
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SEQ = 3'b001,
		ST_ON = 3'b010,
		ST_S3 = 3'b011,
		ST_S4 = 3'b100,
		ST_DEEP = 3'b101
	} mpc_state_e;

	// Request from system software: a sleep target or entry into deep sleep.
	typedef struct packed {
		logic req;
		logic deep;
		logic [1:0] target;
	} mpc_swreq_s;

	// Status shown to the rest of the module.
	typedef struct packed {
		mpc_state_e state;
		mpc_state_e origin;
		logic deep;
		logic ctxKept;
	} mpc_status_s;

endpackage

// ---- hw/mpc_input_filter.sv ----
`timescale 1ns/1ps
module mpc_input_filter
	import mpc_pkg::*;
#(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_n,
	// Raw pin level and its clean copy.
	input wire logic rawIn,
	output logic filtOut
);

	logic sync1_r; // First synchroniser stage, read only by the second.
	logic sync2_r; // Second synchroniser stage.
	logic filt_r; // Accepted level.
	logic filt_nxt;
	logic [FILT_W-1:0] cnt_r; // Cycles the synchronised level has differed from filt_r.
	logic [FILT_W-1:0] cnt_nxt;

	// A new level is accepted only after it has held for FILT_CYC cycles.
	always_comb begin
		filt_nxt = filt_r;
		cnt_nxt = '0;
		if (sync2_r != filt_r) begin
			// Any bounce back to the old level restarts the count.
			if (cnt_r == FILT_W'(FILT_CYC - 1)) begin
				filt_nxt = sync2_r;
			end else begin
				cnt_nxt = cnt_r + FILT_W'(1);
			end
		end
	end

	// Registers only.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= RESET_VAL;
			sync2_r <= RESET_VAL;
			filt_r <= RESET_VAL;
			cnt_r <= '0;
		end else begin
			sync1_r <= rawIn;
			sync2_r <= sync1_r;
			filt_r <= filt_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign filtOut = filt_r;

	// The clean level only moves after the full hold time.
	a_filter_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		(filt_r != $past(filt_r)) |-> ($past(cnt_r) == FILT_W'(FILT_CYC - 1)))
		else $error("filtered level changed before hold time");

endmodule

// ---- test/mpc_carrier_model.sv ----
`timescale 1ns/1ps
// Carrier power hardware: holds power good low, then lets the pin float.
module mpc_carrier_model #(
	parameter int SETTLE_CYC = 100 // Settle delay after rails are up, shortened.
) (
	// Clock and rail status.
	input wire logic mclk,
	input wire logic railsUp,
	// Module pins.
	input wire logic supplyOnN,
	output wire logic powerGoodIn,
	output wire logic mainOn
);
	int cnt = 0; // Cycles since the rails came up.
	// Standby-powered inverter in front of the main supply.
	assign mainOn = ~supplyOnN;
	// Count settle time; any rail drop restarts it.
	always @(posedge mclk) begin
		cnt <= railsUp ? ((cnt < SETTLE_CYC) ? cnt + 1 : cnt) : 0;
	end
	// Drive low, never high; the pull-up on the net gives the good level.
	assign powerGoodIn = (cnt < SETTLE_CYC) ? 1'b0 : 1'bz;
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
	import mpc_pkg::*;
	logic mclk, rst_n, powerButtonN, supplyOnN, buttonToSleep, wakeEvent;
	logic deepWake, railsUp, moduleResetN, mainOn;
	tri1 powerGoodIn; // Pulled up when the carrier lets go.
	mpc_swreq_s swReq;
	logic [RAIL_N-1:0] railEnable;
	mpc_status_s status;
	int bad_count = 0;
	int samples_checked = 0;
	mpc_carrier_model CAR (.mclk(mclk), .railsUp(railsUp), .supplyOnN(supplyOnN),
		.powerGoodIn(powerGoodIn), .mainOn(mainOn));
	mpc_power_control DUT (.mclk(mclk), .rst_n(rst_n), .powerGoodIn(powerGoodIn),
		.powerButtonN(powerButtonN), .supplyOnN(supplyOnN), .swReq(swReq),
		.buttonToSleep(buttonToSleep), .wakeEvent(wakeEvent), .deepWake(deepWake),
		.railEnable(railEnable), .moduleResetN(moduleResetN), .status(status));
	// Clock of 100 ns period.
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// Compare one value and count it.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	// Print counts and verdict, then end.
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Wait at falling edges for a state; a spent bound ends the run.
	task automatic wait_state(input mpc_state_e st, input int bound);
		int n;
		n = 0;
		while (status.state !== st && n < bound) begin
			@(negedge mclk);
			n++;
		end
		check(8'(status.state), 8'(st), "state wait");
		if (status.state !== st) stop_test();
	endtask
	// One-cycle software request.
	task automatic sw(input logic dp, input logic [1:0] tg);
		swReq = '{1'b1, dp, tg};
		@(negedge mclk);
		swReq = '0;
		@(negedge mclk);
	endtask
	// Boot only once the carrier releases power good.
	task automatic t_boot();
		repeat (300) @(negedge mclk);
		check(8'(moduleResetN), 8'h00, "reset held");
		check(8'(railEnable), 8'h00, "rails before good");
		railsUp = 1'b1;
		wait_state(ST_ON, 9000);
		check(8'(railEnable), 8'h07, "rails on");
		check(8'(moduleResetN), 8'h01, "reset released");
		check(8'(mainOn), 8'h01, "supply on");
	endtask
	// A short press is ignored, a long one sleeps.
	task automatic t_button();
		buttonToSleep = 1'b1;
		powerButtonN = 1'b0;
		repeat (50) @(negedge mclk);
		powerButtonN = 1'b1;
		repeat (200) @(negedge mclk);
		check(8'(status.state), 8'(ST_ON), "glitch ignored");
		powerButtonN = 1'b0;
		wait_state(ST_S3, 300);
		powerButtonN = 1'b1;
		check(8'(status.ctxKept), 8'h01, "suspend keeps context");
		check(8'(mainOn), 8'h00, "supply off in suspend");
		repeat (200) @(negedge mclk);
	endtask
	// Deep sleep from a given state, wrong wake refused, right wake returns.
	task automatic t_deep(input mpc_state_e from);
		sw(1'b1, 2'h0);
		check(8'(status.state), 8'(ST_DEEP), "deep entered");
		check(8'(status.origin), 8'(from), "deep origin");
		check(8'(status.deep), 8'h01, "deep flag");
		wakeEvent = 1'b1;
		repeat (3) @(negedge mclk);
		wakeEvent = 1'b0;
		check(8'(status.state), 8'(ST_DEEP), "limited wake");
		deepWake = 1'b1;
		@(negedge mclk);
		deepWake = 1'b0;
		wait_state(from, 3);
	endtask
	// Power good loss while on puts the module back in reset.
	task automatic t_pg_loss();
		int n;
		railsUp = 1'b0;
		wait_state(ST_SEQ, 400);
		check(8'(moduleResetN), 8'h00, "reset on loss");
		railsUp = 1'b1;
		// Catch the first rail, then time the next step against the step length.
		n = 0;
		while (railEnable !== 3'h1 && n < 2500) begin
			@(negedge mclk);
			n++;
		end
		check(8'(railEnable), 8'h01, "first rail");
		if (railEnable !== 3'h1) stop_test();
		repeat (STEP_CYC - 1) @(negedge mclk);
		check(8'(railEnable), 8'h01, "first rail held one step");
		@(negedge mclk);
		check(8'(railEnable), 8'h03, "second rail after one step");
		wait_state(ST_ON, 9000);
	endtask
	// Refused requests, a button that wakes, a button that shuts down, button deep wake.
	task automatic t_btn_off();
		sw(1'b0, TGT_S3);
		check(8'(status.state), 8'(ST_OFF), "target refused when off");
		powerButtonN = 1'b0;
		wait_state(ST_SEQ, 300);
		powerButtonN = 1'b1;
		wait_state(ST_ON, 9000);
		sw(1'b1, 2'h0);
		check(8'(status.state), 8'(ST_ON), "deep refused when on");
		sw(1'b0, 2'h0);
		check(8'(status.state), 8'(ST_ON), "empty target ignored");
		buttonToSleep = 1'b0;
		powerButtonN = 1'b0;
		wait_state(ST_OFF, 300);
		check(8'(status.ctxKept), 8'h00, "button off loses context");
		check(8'(mainOn), 8'h00, "supply off after button");
		powerButtonN = 1'b1;
		repeat (200) @(negedge mclk);
		sw(1'b1, 2'h0);
		check(8'(status.state), 8'(ST_DEEP), "deep from off again");
		powerButtonN = 1'b0;
		wait_state(ST_OFF, 300);
		check(8'(status.deep), 8'h00, "deep flag cleared");
		powerButtonN = 1'b1;
		repeat (200) @(negedge mclk);
	endtask
	// Main sequence.
	initial begin
		rst_n = 1'b0;
		powerButtonN = 1'b1;
		buttonToSleep = 1'b0;
		wakeEvent = 1'b0;
		deepWake = 1'b0;
		railsUp = 1'b0;
		swReq = '0;
		repeat (20) @(negedge mclk);
		rst_n = 1'b1;
		t_boot();
		t_button();
		t_deep(ST_S3);
		wakeEvent = 1'b1;
		@(negedge mclk);
		wakeEvent = 1'b0;
		wait_state(ST_ON, 9000);
		t_pg_loss();
		sw(1'b0, TGT_S4);
		check(8'(status.state), 8'(ST_S4), "hibernate");
		t_deep(ST_S4);
		wakeEvent = 1'b1;
		@(negedge mclk);
		wakeEvent = 1'b0;
		wait_state(ST_ON, 9000);
		sw(1'b0, TGT_S3);
		check(8'(status.state), 8'(ST_S3), "suspend by request");
		check(8'(status.ctxKept), 8'h01, "requested suspend keeps context");
		check(8'(mainOn), 8'h00, "supply off after request");
		wakeEvent = 1'b1;
		@(negedge mclk);
		wakeEvent = 1'b0;
		wait_state(ST_ON, 9000);
		sw(1'b0, TGT_S5);
		check(8'(status.ctxKept), 8'h00, "soft-off loses context");
		t_deep(ST_OFF);
		t_btn_off();
		stop_test();
	end
endmodule
